/* File: bench/dab_mem_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// bus arbiter and memory on the far side of the dma core
// ------------------------------------------------------------
module dab_mem_model (
    input  wire logic        REF_CLK,
    input  wire logic        RST_N,
    input  wire logic        SLOW,
    input  wire logic        BUS_REQ,
    output logic             BUS_GNT,
    input  wire logic [31:0] MEM_ADDR,
    input  wire logic        MEM_RD,
    input  wire logic        MEM_WR,
    output logic      [15:0] MEM_RDATA,
    output logic             MEM_DONE
);
    logic [1:0] gnt_wait_q;
    logic [1:0] cyc_wait_q;

    // grant is held while requested; each strobe ends with a single done pulse
    // outside done the read bus toggles, so stale data never passes for valid
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            BUS_GNT    <= 1'b0;
            MEM_DONE   <= 1'b0;
            MEM_RDATA  <= 16'h0000;
            gnt_wait_q <= 2'h0;
            cyc_wait_q <= 2'h0;
        end else begin
            if (!BUS_REQ) begin
                BUS_GNT    <= 1'b0;
                gnt_wait_q <= SLOW ? 2'h3 : 2'h0;
            end else if (!BUS_GNT && gnt_wait_q == 2'h0) begin
                BUS_GNT <= 1'b1;
            end else if (!BUS_GNT) begin
                gnt_wait_q <= gnt_wait_q - 2'h1;
            end
            if (MEM_DONE || !(MEM_RD || MEM_WR)) begin
                MEM_DONE   <= 1'b0;
                MEM_RDATA  <= ~MEM_RDATA;
                cyc_wait_q <= SLOW ? 2'h2 : 2'h0;
            end else if (cyc_wait_q != 2'h0) begin
                MEM_RDATA  <= ~MEM_RDATA;
                cyc_wait_q <= cyc_wait_q - 2'h1;
            end else begin
                MEM_DONE  <= 1'b1;
                MEM_RDATA <= MEM_ADDR[15:0] ^ {MEM_ADDR[23:16], MEM_ADDR[31:24]} ^ 16'hA5C3;
            end
        end
    end
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top import dab_pkg::*; ;
    logic        REF_CLK = 1'b0;
    logic        RST_N = 1'b0;
    logic [7:0]  REG_ADDR;
    logic [31:0] REG_WDATA, REG_RDATA, MEM_ADDR, d, src, dst, sa, da;
    logic        REG_WR, REG_RD, NMI_EVT, BUS_REQ, BUS_GNT, MEM_RD, MEM_WR, MEM_SIZE16;
    logic        MEM_DONE, SLOW, req_prev, sz_exp;
    logic [1:0]  TRANSFER_REQUEST_PIN_N, TRANSFER_ACK_OUT;
    logic [3:0]  PERIPH_REQ;
    logic [15:0] MEM_WDATA, MEM_RDATA, mk;
    logic [31:0] lfsr_q = 32'h0001_1AB2;
    logic [31:0] ev_addr[$];
    logic [15:0] ev_data[$];
    logic [1:0]  ev_ack[$];
    logic        ev_wr[$];
    logic [31:0] bad_ctl[4];
    logic [1:0]  bad_ch[4];
    int          mismatches, cmp_count, brf, cnt;

    dab_core dab_core_inst (.REF_CLK(REF_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .TRANSFER_REQUEST_PIN_N(TRANSFER_REQUEST_PIN_N), .PERIPH_REQ(PERIPH_REQ),
        .NMI_EVT(NMI_EVT), .BUS_REQ(BUS_REQ), .BUS_GNT(BUS_GNT), .MEM_ADDR(MEM_ADDR),
        .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_SIZE16(MEM_SIZE16), .MEM_WDATA(MEM_WDATA),
        .MEM_RDATA(MEM_RDATA), .MEM_DONE(MEM_DONE), .TRANSFER_ACK_OUT(TRANSFER_ACK_OUT));
    dab_mem_model dab_mem_model_inst (.REF_CLK(REF_CLK), .RST_N(RST_N), .SLOW(SLOW),
        .BUS_REQ(BUS_REQ), .BUS_GNT(BUS_GNT), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD),
        .MEM_WR(MEM_WR), .MEM_RDATA(MEM_RDATA), .MEM_DONE(MEM_DONE));

    // ------------------------------------------------------------
    // helpers: checking, stimulus values and register bus cycles
    // ------------------------------------------------------------
    always #50 REF_CLK = ~REF_CLK;
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    function automatic logic [31:0] rnd();
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q;
    endfunction
    function automatic logic [15:0] mem_word(input logic [31:0] a);
        return a[15:0] ^ {a[23:16], a[31:24]} ^ 16'hA5C3;
    endfunction
    function automatic logic [31:0] step(input logic [31:0] b, input logic [1:0] m,
                                         input int i, input logic sz);
        return (m == AS_INC) ? b + i * (sz ? 2 : 1) : (m == AS_DEC) ? b - i * (sz ? 2 : 1) : b;
    endfunction
    function automatic logic [31:0] mk_ctl(input logic b, input logic [2:0] rq, input logic sz,
        input logic sg, input logic dr, input logic ak, input logic [1:0] sm, input logic [1:0] dm,
        input logic [1:0] st, input logic [1:0] dt);
        return 32'h1 | (b << C_BURST) | (rq << C_RQ) | (sz << C_SZ) | (sg << C_SGL) | (dr << C_DIR)
            | (ak << C_AK) | (sm << C_SM) | (dm << C_DM) | (st << C_ST) | (dt << C_DT);
    endfunction
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        REG_ADDR  <= a;
        REG_WDATA <= v;
        REG_WR    <= 1'b1;
        @(posedge REF_CLK);
        REG_WR    <= 1'b0;
        @(posedge REF_CLK);
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
        REG_ADDR <= a;
        REG_RD   <= 1'b1;
        @(posedge REF_CLK);
        REG_RD   <= 1'b0;
        #1 v = REG_RDATA;
        @(posedge REF_CLK);
    endtask
    task automatic setup(input logic [1:0] ch, input logic [31:0] s, input logic [31:0] t,
                         input int n, input logic [31:0] c);
        ev_addr.delete(); ev_data.delete(); ev_ack.delete(); ev_wr.delete();
        brf = 0;
        sz_exp = c[C_SZ];
        reg_wr({2'b00, ch, R_SRC}, s);
        reg_wr({2'b00, ch, R_DST}, t);
        reg_wr({2'b00, ch, R_CNT}, n);
        reg_wr({2'b00, ch, R_CTL}, c);
    endtask
    task automatic wait_ev(input int n);
        for (int i = 0; i < 3000 && ev_addr.size() < n; i++) @(posedge REF_CLK);
        if (ev_addr.size() < n) begin
            mismatches++;
            stop_test();
        end
    endtask

    // bus monitor: logs finished cycles and bus releases, flags strobes without grant
    always @(posedge REF_CLK) begin
        if (MEM_RD === 1'b1 || MEM_WR === 1'b1) chk("grant", BUS_GNT, 1);
        if (MEM_RD === 1'b1 || MEM_WR === 1'b1) chk("size", MEM_SIZE16, sz_exp);
        if (MEM_DONE === 1'b1) begin
            ev_addr.push_back(MEM_ADDR);
            ev_wr.push_back(MEM_WR);
            ev_ack.push_back(TRANSFER_ACK_OUT);
            ev_data.push_back(MEM_WR ? MEM_WDATA : MEM_RDATA);
        end
        if (req_prev === 1'b1 && BUS_REQ === 1'b0) brf++;
        req_prev = BUS_REQ;
    end

    // dual address run with random ends and count; checks pairing, steps, ack and end flag
    task automatic dual_case(input logic [1:0] ch, input logic b, input logic [2:0] rq,
        input logic sz, input logic ak, input logic [1:0] sm, input logic [1:0] dm,
        input logic [1:0] st, input logic [1:0] dt);
        src = {16'h0010, 16'(rnd() & 32'hFFFE)} + 32'h100;
        dst = {16'h0020, 16'(rnd() & 32'hFFFE)} + 32'h100;
        cnt = 2 + (rnd() % 4);
        mk  = sz ? 16'hFFFF : 16'h00FF;
        setup(ch, src, dst, cnt, mk_ctl(b, rq, sz, 1'b0, 1'b0, ak, sm, dm, st, dt));
        wait_ev(2 * cnt);
        repeat (8) @(posedge REF_CLK);
        chk("units", ev_addr.size(), 2 * cnt);
        chk("bus_drops", brf, b ? 1 : cnt);
        for (int i = 0; i < cnt; i++) begin
            sa = step(src, sm, i, sz);
            da = step(dst, dm, i, sz);
            chk("rd_addr", ev_addr[2*i], sa);
            chk("rd_kind", ev_wr[2*i], 0);
            chk("rd_ack", ev_ack[2*i], (ch < 2 && st != EP_IMEM && !ak) ? 1 << ch : 0);
            chk("wr_addr", ev_addr[2*i+1], da);
            chk("wr_data", ev_data[2*i+1] & mk, mem_word(sa) & mk);
            chk("wr_ack", ev_ack[2*i+1], (ch < 2 && dt != EP_IMEM && ak) ? 1 << ch : 0);
        end
        reg_rd({2'b00, ch, R_CTL}, d);
        chk("end_flag", d[C_EF], 1);
        reg_rd({2'b00, ch, R_CNT}, d);
        chk("count", d, 0);
    endtask

    // main sequence
    initial begin
        {REG_ADDR, REG_WDATA, REG_WR, REG_RD, NMI_EVT, SLOW, req_prev} = '0;
        TRANSFER_REQUEST_PIN_N = 2'b11;
        PERIPH_REQ = 4'hF;
        repeat (12) @(posedge REF_CLK);
        RST_N <= 1'b1;
        @(posedge REF_CLK);
        reg_rd(R_CTL, d);
        chk("ctl_reset", d, 0);
        reg_rd(R_STAT, d);
        chk("stat_reset", d, 0);
        reg_wr(8'h80, 32'hFFFF_FFFF);
        reg_rd(8'h80, d);
        chk("unmapped", d, 0);
        reg_wr(R_OPR, 32'h1);
        dual_case(2'd0, 1'b0, RQ_AUTO, 1'b1, 1'b0, AS_INC, AS_INC, EP_XMEM, EP_XDEV);
        SLOW <= 1'b1;
        dual_case(2'd0, 1'b1, RQ_PER, 1'b0, 1'b1, AS_FIX, AS_DEC, EP_IMEM, EP_XMEM);
        dual_case(2'd3, 1'b0, RQ_PER, 1'b1, 1'b0, AS_DEC, AS_INC, EP_XMEM, EP_IMEM);
        SLOW <= 1'b0;
        // single address on channel 1: write form, then read form with a mid-run release
        for (int p = 0; p < 2; p++) begin
            cnt = p ? 8 : 3;
            src = 32'h0030_0000;
            dst = 32'h0040_0000;
            setup(2'd1, src, dst, cnt, mk_ctl(1'b1, RQ_EXT, 1'b1, 1'b1, !p, p, AS_INC, AS_INC,
                  EP_XDEV, EP_XMEM));
            TRANSFER_REQUEST_PIN_N <= 2'b01;
            if (p) begin
                wait_ev(2);
                TRANSFER_REQUEST_PIN_N <= 2'b11;
                repeat (30) @(posedge REF_CLK);
                chk("held_early", ev_addr.size() < cnt, 1);
                chk("bus_free", BUS_REQ, 0);
                TRANSFER_REQUEST_PIN_N <= 2'b01;
            end
            wait_ev(cnt);
            TRANSFER_REQUEST_PIN_N <= 2'b11;
            repeat (8) @(posedge REF_CLK);
            chk("sgl_units", ev_addr.size(), cnt);
            chk("sgl_drops", brf, p + 1);
            for (int i = 0; i < cnt; i++) begin
                chk("sgl_addr", ev_addr[i], (p ? src : dst) + 2 * i);
                chk("sgl_kind", ev_wr[i], !p);
                chk("sgl_ack", ev_ack[i], 2'b10);
            end
        end
        // combinations that must never run
        bad_ch  = '{2'd2, 2'd3, 2'd1, 2'd3};
        bad_ctl[0] = mk_ctl(0, RQ_EXT, 0, 1, 0, 0, AS_INC, AS_INC, EP_XDEV, EP_XMEM);
        bad_ctl[1] = mk_ctl(1, RQ_SER, 0, 0, 0, 0, AS_INC, AS_FIX, EP_XMEM, EP_PERI);
        bad_ctl[2] = mk_ctl(0, RQ_SER, 0, 0, 0, 0, AS_INC, AS_INC, EP_XMEM, EP_XMEM);
        bad_ctl[3] = mk_ctl(0, RQ_EXT, 0, 0, 0, 0, AS_INC, AS_INC, EP_XMEM, EP_XMEM);
        for (int i = 0; i < 4; i++) begin
            setup(bad_ch[i], 32'h0050_0000, 32'h0060_0000, 2, bad_ctl[i]);
            repeat (10) @(posedge REF_CLK);
            reg_rd(R_STAT, d);
            chk("illegal", d[4 + bad_ch[i]], 1);
            chk("no_units", ev_addr.size(), 0);
            reg_wr({2'b00, bad_ch[i], R_CTL}, 32'h0);
        end
        // own register window as source raises the address error flag
        setup(2'd0, OWN_BASE, 32'h0060_0000, 2,
              mk_ctl(0, RQ_AUTO, 0, 0, 0, 0, AS_INC, AS_INC, EP_PERI, EP_XMEM));
        repeat (20) @(posedge REF_CLK);
        reg_rd(R_OPR, d);
        chk("addr_err", d[2:0], 3'h5);
        chk("own_units", ev_addr.size(), 0);
        reg_wr(R_CTL, 32'h0);
        reg_wr(R_OPR, 32'h1);
        // nmi flag blocks an otherwise ready channel
        NMI_EVT <= 1'b1;
        @(posedge REF_CLK);
        NMI_EVT <= 1'b0;
        reg_rd(R_OPR, d);
        chk("nmi_flag", d[2:0], 3'h3);
        setup(2'd0, 32'h0050_0000, 32'h0060_0000, 2,
              mk_ctl(0, RQ_AUTO, 0, 0, 0, 0, AS_INC, AS_INC, EP_XMEM, EP_XMEM));
        repeat (20) @(posedge REF_CLK);
        chk("nmi_units", ev_addr.size(), 0);
        chk("nmi_req", BUS_REQ, 0);
        stop_test();
    end

    // hang guard at 90000 clock periods, far beyond the normal run length
    initial begin
        #9000000;
        mismatches++;
        stop_test();
    end
endmodule

/* File: rtl/dab_core.sv */
`timescale 1ns/1ps
module dab_core import dab_pkg::*; #(
    parameter int ADDR_W = 32
) (
    input  wire logic              REF_CLK,
    input  wire logic              RST_N,
    input  wire logic [7:0]        REG_ADDR,
    input  wire logic [31:0]       REG_WDATA,
    input  wire logic              REG_WR,
    input  wire logic              REG_RD,
    output logic      [31:0]       REG_RDATA,
    input  wire logic [1:0]        TRANSFER_REQUEST_PIN_N,
    input  wire logic [NCH-1:0]    PERIPH_REQ,
    input  wire logic              NMI_EVT,
    output logic                   BUS_REQ,
    input  wire logic              BUS_GNT,
    output logic      [ADDR_W-1:0] MEM_ADDR,
    output logic                   MEM_RD,
    output logic                   MEM_WR,
    output logic                   MEM_SIZE16,
    output logic      [15:0]       MEM_WDATA,
    input  wire logic [15:0]       MEM_RDATA,
    input  wire logic              MEM_DONE,
    output logic      [1:0]        TRANSFER_ACK_OUT
);
    //--------------------------------------------------------------
    // state
    //--------------------------------------------------------------
    typedef struct packed {
        logic [NCH-1:0][ADDR_W-1:0] src;
        logic [NCH-1:0][ADDR_W-1:0] dst;
        logic [NCH-1:0][15:0]       cnt;
        logic [NCH-1:0][CTL_W-1:0]  ctl;
        logic                       men;
        logic                       nmi;
        logic                       af;
        dab_state_e                 st;
        logic [1:0]                 ch;
        logic [NCH-1:0]             cs_blk;
        logic [1:0]                 pin_m;
        logic [1:0]                 pin_s;
        logic [31:0]                rdata;
        logic                       breq;
        logic                       rd;
        logic                       wr;
        logic                       sz16;
        logic [ADDR_W-1:0]          addr;
        logic [15:0]                wdata;
        logic [1:0]                 ack;
    } dab_st_s;

    dab_st_s        q;
    dab_st_s        n;
    logic [NCH-1:0] ok;
    logic [NCH-1:0] req;
    logic [NCH-1:0] go;
    logic [NCH-1:0] brst;
    logic [3:0]     ext_lvl;

    //--------------------------------------------------------------
    // decode helpers
    //--------------------------------------------------------------
    // fixed order ch0 > ch3 > ch2 > ch1
    function automatic logic [1:0] pick(input logic [NCH-1:0] m);
        if (m[0]) begin
            pick = 2'h0;
        end else if (m[3]) begin
            pick = 2'h3;
        end else if (m[2]) begin
            pick = 2'h2;
        end else begin
            pick = 2'h1;
        end
    endfunction

    function automatic logic [1:0] onehot(input logic [1:0] c);
        onehot = (c == 2'h0) ? 2'h1 : ((c == 2'h1) ? 2'h2 : 2'h0);
    endfunction

    function automatic logic is_ext(input logic [1:0] t);
        is_ext = (t == EP_XMEM) || (t == EP_XDEV);
    endfunction

    // combinations the hardware refuses to run
    function automatic logic legal(input logic [CTL_W-1:0] c, input logic [1:0] ch);
        logic [2:0] rq;
        logic       per;
        rq  = c[C_RQ+:3];
        per = (c[C_ST+:2] == EP_PERI) || (c[C_DT+:2] == EP_PERI);
        legal = (rq <= RQ_ADC);
        if (rq == RQ_EXT && ch > 2'h1) begin
            legal = 1'b0;
        end
        if (c[C_SGL]) begin
            if (rq != RQ_EXT || ch > 2'h1) begin
                legal = 1'b0;
            end
            if (!is_ext(c[C_ST+:2]) || !is_ext(c[C_DT+:2])) begin
                legal = 1'b0;
            end
        end else if ((rq == RQ_SER || rq == RQ_ADC) && !per) begin
            legal = 1'b0;
        end
        if (rq == RQ_SER && c[C_BURST]) begin
            legal = 1'b0;
        end
        // cycle-steal carries no further limit
    endfunction

    // own register window, or a word access at an odd address
    function automatic logic bad(input logic [ADDR_W-1:0] a, input logic sz);
        bad = ((a & ADDR_W'(OWN_MASK)) == ADDR_W'(OWN_BASE)) || (sz && a[0]);
    endfunction

    function automatic logic [ADDR_W-1:0] step(
        input logic [ADDR_W-1:0] a,
        input logic [1:0]        m,
        input logic              sz
    );
        logic [ADDR_W-1:0] d;
        d = sz ? ADDR_W'(STEP_W) : ADDR_W'(STEP_B);
        case (m)
            AS_INC:  step = a + d;
            AS_DEC:  step = a - d;
            default: step = a;
        endcase
    endfunction

    // opens one unit on channel c; errors halt without a bus cycle
    function automatic dab_st_s start(input dab_st_s s, input logic [1:0] c);
        dab_st_s          r;
        logic [CTL_W-1:0] cc;
        logic             dir;
        r      = s;
        cc     = s.ctl[c];
        dir    = cc[C_DIR];
        r.ch   = c;
        r.sz16 = cc[C_SZ];
        if (cc[C_SGL]) begin
            // acked end is source: address the other end in a write
            r.addr = dir ? s.dst[c] : s.src[c];
            if (bad(r.addr, cc[C_SZ])) begin
                r.af   = 1'b1;
                r.st   = S_IDLE;
                r.breq = 1'b0;
            end else begin
                r.st  = S_SGL;
                r.wr  = dir;
                r.rd  = !dir;
                r.ack = onehot(c);
            end
        end else if (bad(s.src[c], cc[C_SZ]) || bad(s.dst[c], cc[C_SZ])) begin
            r.af   = 1'b1;
            r.st   = S_IDLE;
            r.breq = 1'b0;
        end else begin
            r.st   = S_RD;
            r.rd   = 1'b1;
            r.addr = s.src[c];
            r.ack  = (!cc[C_AK] && is_ext(cc[C_ST+:2])) ? onehot(c) : 2'h0;
        end
        start = r;
    endfunction

    //--------------------------------------------------------------
    // per-channel readiness
    //--------------------------------------------------------------
    // pin requests are active low and only exist on channels 0 and 1
    assign ext_lvl = {2'h0, ~q.pin_s};

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            logic [2:0] rq;
            assign rq    = q.ctl[g][C_RQ+:3];
            assign ok[g] = legal(q.ctl[g], 2'(g));
            assign req[g] = (rq == RQ_AUTO) ? 1'b1 :
                            (rq == RQ_EXT)  ? ext_lvl[g] : PERIPH_REQ[g];
            // a high pin drops readiness, so burst lets go of the bus
            assign go[g] = q.ctl[g][C_EN] && q.men && !q.ctl[g][C_EF]
                           && !q.nmi && !q.af && ok[g] && req[g]
                           && (q.cnt[g] != 16'h0000);
            assign brst[g] = q.ctl[g][C_BURST];
        end
    endgenerate

    //--------------------------------------------------------------
    // next state
    //--------------------------------------------------------------
    always_comb begin
        logic [1:0]     idx;
        logic [1:0]     c;
        logic [NCH-1:0] cand;
        n       = q;
        idx     = REG_ADDR[5:4];
        c       = q.ch;
        cand    = '0;
        n.pin_m = TRANSFER_REQUEST_PIN_N;
        n.pin_s = q.pin_m;
        n.rdata = '0;
        // software reads: data stands only in the following cycle
        if (REG_RD) begin
            if (REG_ADDR < R_OPR) begin
                case (REG_ADDR[3:0])
                    R_SRC:   n.rdata = 32'(q.src[idx]);
                    R_DST:   n.rdata = 32'(q.dst[idx]);
                    R_CNT:   n.rdata = 32'(q.cnt[idx]);
                    R_CTL:   n.rdata = 32'(q.ctl[idx]);
                    default: n.rdata = '0;
                endcase
            end else if (REG_ADDR == R_OPR) begin
                n.rdata = 32'({q.af, q.nmi, q.men});
            end else if (REG_ADDR == R_STAT) begin
                n.rdata = 32'({q.ch, q.st, ~ok, go});
            end
        end
        // software writes; end and fault flags can only be cleared
        if (REG_WR) begin
            if (REG_ADDR < R_OPR) begin
                case (REG_ADDR[3:0])
                    R_SRC: n.src[idx] = ADDR_W'(REG_WDATA);
                    R_DST: n.dst[idx] = ADDR_W'(REG_WDATA);
                    R_CNT: n.cnt[idx] = REG_WDATA[15:0];
                    R_CTL: begin
                        n.ctl[idx] = REG_WDATA[CTL_W-1:0];
                        n.ctl[idx][C_EF] = q.ctl[idx][C_EF] & REG_WDATA[C_EF];
                    end
                    default: n.cnt = q.cnt;
                endcase
            end else if (REG_ADDR == R_OPR) begin
                n.men  = REG_WDATA[O_MEN];
                n.nmi  = q.nmi & REG_WDATA[O_NMI];
                n.af   = q.af & REG_WDATA[O_AF];
            end
        end
        // nmi after the write so the set wins
        if (NMI_EVT) begin
            n.nmi = 1'b1;
        end
        // transfer sequencer; hardware updates override same-cycle writes
        case (q.st)
            S_IDLE: begin
                n.cs_blk = '0;
                if (|go) begin
                    n.breq = 1'b1;
                    n.st   = S_BREQ;
                end
            end
            S_BREQ: begin
                if (BUS_GNT) begin
                    if (|go) begin
                        n = start(n, pick(go));
                    end else begin
                        n.breq = 1'b0;
                        n.st   = S_IDLE;
                    end
                end
            end
            S_RD: begin
                if (MEM_DONE) begin
                    // data held internally for the separate write
                    n.wdata = MEM_RDATA;
                    n.rd    = 1'b0;
                    n.wr    = 1'b1;
                    n.addr  = q.dst[c];
                    n.ack   = (q.ctl[c][C_AK] && is_ext(q.ctl[c][C_DT+:2]))
                              ? onehot(c) : 2'h0;
                    n.st    = S_WR;
                end
            end
            S_WR, S_SGL: begin
                if (MEM_DONE) begin
                    n.rd     = 1'b0;
                    n.wr     = 1'b0;
                    n.ack    = 2'h0;
                    n.src[c] = step(q.src[c], q.ctl[c][C_SM+:2], q.sz16);
                    n.dst[c] = step(q.dst[c], q.ctl[c][C_DM+:2], q.sz16);
                    n.cnt[c] = q.cnt[c] - CNT_LAST;
                    if (q.cnt[c] == CNT_LAST) begin
                        n.ctl[c][C_EF] = 1'b1;
                    end
                    // a cycle-steal unit yields one turn to the other ready channels, picked by priority, only while a live burst channel keeps the bus
                    n.cs_blk[c] = !q.ctl[c][C_BURST];
                    n.st = S_NEXT;
                end
            end
            S_NEXT: begin
                cand = go & ~q.cs_blk;
                if (cand == '0) begin
                    cand = go;
                end
                n.cs_blk = '0;
                // any live burst channel keeps the bus
                if ((|(go & brst)) && BUS_GNT) begin
                    n = start(n, pick(cand));
                end else begin
                    n.breq = 1'b0;
                    n.st   = S_IDLE;
                end
            end
            default: begin
                n.st   = S_IDLE;
                n.breq = 1'b0;
                n.rd   = 1'b0;
                n.wr   = 1'b0;
                n.ack  = 2'h0;
            end
        endcase
    end

    // single register stage for all state
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    //--------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------
    assign REG_RDATA        = q.rdata;
    assign BUS_REQ          = q.breq;
    assign MEM_ADDR         = q.addr;
    assign MEM_RD           = q.rd;
    assign MEM_WR           = q.wr;
    assign MEM_SIZE16       = q.sz16;
    assign MEM_WDATA        = q.wdata;
    assign TRANSFER_ACK_OUT = q.ack;

    //--------------------------------------------------------------
    // checks
    //--------------------------------------------------------------
    logic             fin;
    logic [15:0]      cur_cnt;
    logic [CTL_W-1:0] cur_ctl;
    assign fin     = (q.st == S_WR || q.st == S_SGL) && MEM_DONE;
    assign cur_cnt = q.cnt[q.ch];
    assign cur_ctl = q.ctl[q.ch];

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    single_cycle_a: assert property (
        q.st == S_SGL |-> (MEM_RD ^ MEM_WR) && $onehot(TRANSFER_ACK_OUT))
        else $error("single unit lacks one strobe and one ack");
    single_source_a: assert property (
        q.st == S_SGL |-> cur_ctl[C_RQ+:3] == RQ_EXT && q.ch < 2'h2)
        else $error("single unit on wrong request or channel");
    read_then_write_a: assert property (
        q.st == S_RD && MEM_DONE |=> MEM_WR && !MEM_RD && MEM_ADDR == q.dst[q.ch])
        else $error("read not followed by write to destination");
    grant_first_a: assert property (
        q.st == S_BREQ && !BUS_GNT |=> !MEM_RD && !MEM_WR && BUS_REQ)
        else $error("bus cycle before grant");
    steal_release_a: assert property (
        q.st == S_NEXT && !(|(go & brst)) |=> !BUS_REQ ##1 !MEM_RD && !MEM_WR)
        else $error("cycle-steal unit kept the bus");
    count_step_a: assert property (
        fin |=> cur_cnt == $past(cur_cnt) - CNT_LAST)
        else $error("count not decremented by one");
    end_flag_a: assert property (
        fin && cur_cnt == CNT_LAST |=> cur_ctl[C_EF])
        else $error("end flag not set on last unit");
    enable_gate_a: assert property (
        (q.st == S_BREQ || q.st == S_NEXT) && !(|go) |=> !MEM_RD && !MEM_WR)
        else $error("unit started with no channel ready");
    serial_steal_a: assert property (
        q.rd || q.wr |-> !(cur_ctl[C_RQ+:3] == RQ_SER && cur_ctl[C_BURST]))
        else $error("serial request running in burst");
endmodule

/* File: rtl/dab_pkg.sv */
//------------------------------------------------------------------
//------------------------------------------------------------------
package dab_pkg;
    localparam int NCH = 4;
    // register map: channel area then operation and status
    localparam logic [3:0] R_SRC  = 4'h0;
    localparam logic [3:0] R_DST  = 4'h4;
    localparam logic [3:0] R_CNT  = 4'h8;
    localparam logic [3:0] R_CTL  = 4'hC;
    localparam logic [7:0] R_OPR  = 8'h40;
    localparam logic [7:0] R_STAT = 8'h44;
    // channel control fields
    localparam int C_EN    = 0;
    localparam int C_EF    = 1;
    localparam int C_BURST = 2;
    localparam int C_RQ    = 3;
    localparam int C_SZ    = 6;
    localparam int C_SGL   = 7;
    localparam int C_DIR   = 8;
    localparam int C_AK    = 9;
    localparam int C_SM    = 10;
    localparam int C_DM    = 12;
    localparam int C_ST    = 14;
    localparam int C_DT    = 16;
    localparam int CTL_W   = 18;
    // operation register fields
    localparam int O_MEN  = 0;
    localparam int O_NMI  = 1;
    localparam int O_AF   = 2;
    // request sources
    localparam logic [2:0] RQ_AUTO = 3'h0;
    localparam logic [2:0] RQ_EXT  = 3'h1;
    localparam logic [2:0] RQ_PER  = 3'h2;
    localparam logic [2:0] RQ_SER  = 3'h3;
    localparam logic [2:0] RQ_ADC  = 3'h4;
    // endpoint kinds
    localparam logic [1:0] EP_XMEM = 2'h0;
    localparam logic [1:0] EP_XDEV = 2'h1;
    localparam logic [1:0] EP_IMEM = 2'h2;
    localparam logic [1:0] EP_PERI = 2'h3;
    // address step modes
    localparam logic [1:0] AS_FIX = 2'h0;
    localparam logic [1:0] AS_INC = 2'h1;
    localparam logic [1:0] AS_DEC = 2'h2;
    localparam int STEP_B = 1;
    localparam int STEP_W = 2;
    localparam logic [15:0] CNT_LAST = 16'h0001;
    // window holding the controller's own registers
    localparam logic [31:0] OWN_BASE = 32'hFFFF_FF00;
    localparam logic [31:0] OWN_MASK = 32'hFFFF_FF00;
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_BREQ = 3'b001,
        S_RD   = 3'b010,
        S_WR   = 3'b011,
        S_SGL  = 3'b100,
        S_NEXT = 3'b101
    } dab_state_e;
endpackage
